// ### design/osc_params.svh
// Offsets, field positions, reset values and timing counts of the oscillator control block
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH
`define OSC_CTRL_ADDR 4'h0
`define OSC_UNLOCK_ADDR 4'h4
`define OSC_KEY1 32'hAA996655
`define OSC_KEY2 32'h556699AA
`define POS_PLL_ODIV 27
`define POS_FRC_DIV 24
`define POS_SOSC_RDY 22
`define POS_PB_RDY 21
`define POS_PB_DIV 19
`define POS_PLL_MULT 16
`define POS_CUR_SRC 12
`define POS_NEW_SRC 8
`define POS_CLK_LOCK 7
`define POS_USB_LOCK 6
`define POS_PLL_LOCK 5
`define POS_SLP_EN 4
`define POS_CLK_FAIL 3
`define POS_USB_FRC 2
`define POS_SOSC_EN 1
`define POS_SWITCH 0
`define FRC_DIV_RST 3'h1
`define PB_SETTLE_CYC 4'h4
`endif

// ### design/osc_pkg.sv
// Types shared by the oscillator control block
`default_nettype none
package osc_pkg;
    typedef struct packed {
        logic [2:0] pll_output_divide;
        logic [1:0] periph_clock_divide;
        logic [2:0] pll_multiplier;
        logic [2:0] new_source_select;
        logic secondary_osc_enable;
    } osc_cfg_t;
    typedef struct packed {
        logic [2:0] pll_output_divide;
        logic [2:0] fast_rc_divide;
        logic [1:0] periph_clock_divide;
        logic [2:0] pll_multiplier;
        logic [2:0] current_source;
        logic [2:0] new_source_select;
        logic clock_lock;
        logic sleep_enable;
        logic clock_fail;
        logic usb_frc_enable;
        logic secondary_osc_enable;
        logic switch_request;
    } osc_ctrl_t;
    typedef enum logic [1:0] {LOCKED, KEY1_SEEN, UNLOCKED} lock_state_t;
    typedef enum logic {SW_IDLE, SW_SWITCH} switch_state_t;
endpackage
`default_nettype wire

// ### design/oscillator_control_register.sv
// Oscillator control register with unlock guard, clock source switch and clock dividers
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "osc_params.svh"
module oscillator_control_register
    import osc_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    input wire logic clock, // System clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic ce, // Clock enable, freezes state when low
    input wire logic [ADDR_W-1:0] addr, // Register byte address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr_en, // Write strobe
    input wire logic rd_en, // Read strobe
    output logic [31:0] rdata_q, // Read data, cycle after read strobe
    input wire osc_cfg_t cfg, // Configuration bits
    input wire logic sosc_stable, // Secondary oscillator running and stable
    input wire logic pll_lock, // System PLL locked
    input wire logic usb_pll_lock, // USB PLL locked
    input wire logic pll_tick, // One pulse per PLL output cycle
    input wire logic frc_tick, // One pulse per fast RC cycle
    output osc_ctrl_t ctrl_q, // Control fields
    output logic sosc_rdy_q, // Secondary oscillator ready
    output logic pb_rdy_q, // Peripheral divisor writable
    output logic [2:0] div_tick_q // Divided ticks: pll, fast RC, peripheral bus
);

////////////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic ctrl_wr;
    logic unlock_wr;
    logic ctrl_ok;
    lock_state_t lock_q;
    lock_state_t lock_d;
    switch_state_t sw_q;
    switch_state_t sw_d;
    assign ctrl_wr = wr_en && (addr == `OSC_CTRL_ADDR);
    assign unlock_wr = wr_en && (addr == `OSC_UNLOCK_ADDR);
    assign ctrl_ok = ctrl_wr && (lock_q == UNLOCKED);

////////////////////////////////////////////////////////////////////////////////
    // Unlock sequence: key one then key two, consumed by one control write
    always_comb begin
        lock_d = lock_q;
        if (ctrl_wr) begin
            lock_d = LOCKED;
        end else if (unlock_wr) begin
            case (lock_q)
                LOCKED: lock_d = (wdata == `OSC_KEY1) ? KEY1_SEEN : LOCKED;
                KEY1_SEEN: lock_d = (wdata == `OSC_KEY2) ? UNLOCKED : LOCKED;
                UNLOCKED: lock_d = LOCKED;
                default: lock_d = LOCKED;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            lock_q <= LOCKED;
        end else if (ce) begin
            lock_q <= lock_d;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Control fields
    osc_ctrl_t ctrl_d;
    logic [3:0] pb_cnt_q;
    logic [3:0] pb_cnt_d;
    logic pb_rdy_d;
    always_comb begin
        ctrl_d = ctrl_q;
        pb_cnt_d = (pb_cnt_q != 4'h0) ? pb_cnt_q - 4'h1 : 4'h0;
        if (sw_q == SW_SWITCH) begin
            ctrl_d.current_source = ctrl_q.new_source_select;
            ctrl_d.switch_request = 1'b0;
        end
        if (ctrl_ok) begin
            ctrl_d.pll_output_divide = wdata[`POS_PLL_ODIV+2:`POS_PLL_ODIV];
            ctrl_d.fast_rc_divide = wdata[`POS_FRC_DIV+2:`POS_FRC_DIV];
            if (pb_rdy_q) begin
                ctrl_d.periph_clock_divide = wdata[`POS_PB_DIV+1:`POS_PB_DIV];
                if (wdata[`POS_PB_DIV+1:`POS_PB_DIV] != ctrl_q.periph_clock_divide) begin
                    pb_cnt_d = `PB_SETTLE_CYC;
                end
            end
            ctrl_d.pll_multiplier = wdata[`POS_PLL_MULT+2:`POS_PLL_MULT];
            ctrl_d.new_source_select = wdata[`POS_NEW_SRC+2:`POS_NEW_SRC];
            ctrl_d.clock_lock = wdata[`POS_CLK_LOCK];
            ctrl_d.sleep_enable = wdata[`POS_SLP_EN];
            ctrl_d.clock_fail = wdata[`POS_CLK_FAIL];
            ctrl_d.usb_frc_enable = wdata[`POS_USB_FRC];
            ctrl_d.secondary_osc_enable = wdata[`POS_SOSC_EN];
            if (wdata[`POS_SWITCH]) begin
                ctrl_d.switch_request = 1'b1;
            end else if (sw_q != SW_SWITCH) begin
                ctrl_d.switch_request = 1'b0;
            end
        end
        pb_rdy_d = (pb_cnt_d == 4'h0);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl_q <= '0;
            ctrl_q.pll_output_divide <= cfg.pll_output_divide;
            ctrl_q.fast_rc_divide <= `FRC_DIV_RST;
            ctrl_q.periph_clock_divide <= cfg.periph_clock_divide;
            ctrl_q.pll_multiplier <= cfg.pll_multiplier;
            ctrl_q.new_source_select <= cfg.new_source_select;
            ctrl_q.current_source <= cfg.new_source_select;
            ctrl_q.secondary_osc_enable <= cfg.secondary_osc_enable;
            pb_cnt_q <= 4'h0;
            pb_rdy_q <= 1'b1;
        end else if (ce) begin
            ctrl_q <= ctrl_d;
            pb_cnt_q <= pb_cnt_d;
            pb_rdy_q <= pb_rdy_d;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Source switch sequencer
    always_comb begin
        sw_d = sw_q;
        case (sw_q)
            SW_IDLE: sw_d = ctrl_q.switch_request ? SW_SWITCH : SW_IDLE;
            SW_SWITCH: sw_d = SW_IDLE;
            default: sw_d = SW_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sw_q <= SW_IDLE;
        end else if (ce) begin
            sw_q <= sw_d;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Status and read data
    logic sosc_rdy_d;
    logic pll_lock_q;
    logic usb_lock_q;
    logic [31:0] rdata_d;
    logic [31:0] view;
    always_comb begin
        sosc_rdy_d = sosc_stable && ctrl_q.secondary_osc_enable;
        view = 32'h0;
        view[`POS_PLL_ODIV+2:`POS_PLL_ODIV] = ctrl_q.pll_output_divide;
        view[`POS_FRC_DIV+2:`POS_FRC_DIV] = ctrl_q.fast_rc_divide;
        view[`POS_SOSC_RDY] = sosc_rdy_q;
        view[`POS_PB_RDY] = pb_rdy_q;
        view[`POS_PB_DIV+1:`POS_PB_DIV] = ctrl_q.periph_clock_divide;
        view[`POS_PLL_MULT+2:`POS_PLL_MULT] = ctrl_q.pll_multiplier;
        view[`POS_CUR_SRC+2:`POS_CUR_SRC] = ctrl_q.current_source;
        view[`POS_NEW_SRC+2:`POS_NEW_SRC] = ctrl_q.new_source_select;
        view[`POS_CLK_LOCK] = ctrl_q.clock_lock;
        view[`POS_USB_LOCK] = usb_lock_q;
        view[`POS_PLL_LOCK] = pll_lock_q;
        view[`POS_SLP_EN] = ctrl_q.sleep_enable;
        view[`POS_CLK_FAIL] = ctrl_q.clock_fail;
        view[`POS_USB_FRC] = ctrl_q.usb_frc_enable;
        view[`POS_SOSC_EN] = ctrl_q.secondary_osc_enable;
        view[`POS_SWITCH] = ctrl_q.switch_request;
        rdata_d = (rd_en && (addr == `OSC_CTRL_ADDR)) ? view : 32'h0;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            sosc_rdy_q <= 1'b0;
            pll_lock_q <= 1'b0;
            usb_lock_q <= 1'b0;
            rdata_q <= 32'h0;
        end else if (ce) begin
            sosc_rdy_q <= sosc_rdy_d;
            pll_lock_q <= pll_lock;
            usb_lock_q <= usb_pll_lock;
            rdata_q <= rdata_d;
        end
    end

////////////////////////////////////////////////////////////////////////////////
    // Tick dividers: PLL output, fast RC, peripheral bus
    function automatic logic [7:0] last_count(input logic [2:0] code);
        logic [3:0] sh;
        sh = (code == 3'h7) ? 4'h8 : {1'b0, code};
        last_count = 8'(({1'b0, 8'h1} << sh) - 9'h1);
    endfunction

    logic [2:0] tick_in;
    logic [2:0] code [3];
    assign tick_in = {1'b1, frc_tick, pll_tick};
    assign code[0] = ctrl_q.pll_output_divide;
    assign code[1] = ctrl_q.fast_rc_divide;
    assign code[2] = {1'b0, ctrl_q.periph_clock_divide};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_div
            logic [7:0] cnt_q;
            logic [7:0] cnt_d;
            logic tick_d;
            // Count input ticks and pulse at the last one
            always_comb begin
                cnt_d = cnt_q;
                tick_d = 1'b0;
                if (tick_in[gi]) begin
                    if (cnt_q >= last_count(code[gi])) begin
                        cnt_d = 8'h0;
                        tick_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 8'h1;
                    end
                end
            end

            always_ff @(posedge clock) begin
                if (rst) begin
                    cnt_q <= 8'h0;
                    div_tick_q[gi] <= 1'b0;
                end else if (ce) begin
                    cnt_q <= cnt_d;
                    div_tick_q[gi] <= tick_d;
                end
            end

            chk_div_terminal: assert property (@(posedge clock) disable iff (rst)
                ce && tick_in[gi] && (cnt_q == last_count(code[gi])) |=> div_tick_q[gi])
                else $error("divider missed its terminal count");
        end
    endgenerate

////////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_rsvd_zero: assert property (@(posedge clock) disable iff (rst)
        rdata_q[31:30] == 2'h0 && !rdata_q[23])
        else $error("reserved read bits not zero");

    chk_reset_defaults: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> ctrl_q.fast_rc_divide == `FRC_DIV_RST)
        else $error("fast RC divider reset value wrong");

    chk_cfg_load: assert property (@(posedge clock) disable iff (rst)
        $fell(rst) |-> ctrl_q.periph_clock_divide == $past(cfg.periph_clock_divide)
            && ctrl_q.pll_output_divide == $past(cfg.pll_output_divide))
        else $error("configuration bits not loaded");

    chk_locked_reject: assert property (@(posedge clock) disable iff (rst)
        ce && ctrl_wr && lock_q != UNLOCKED && sw_q == SW_IDLE |=> $stable(ctrl_q))
        else $error("locked write changed control");

    chk_periph_clock_divide_guard: assert property (@(posedge clock) disable iff (rst)
        ce && ctrl_wr && !pb_rdy_q |=> $stable(ctrl_q.periph_clock_divide))
        else $error("peripheral divisor written while busy");

    chk_switch_done: assert property (@(posedge clock) disable iff (rst)
        ce && sw_q == SW_SWITCH && !ctrl_ok |=> !ctrl_q.switch_request
            && ctrl_q.current_source == $past(ctrl_q.new_source_select))
        else $error("source switch not completed");

    chk_sosc_ready: assert property (@(posedge clock) disable iff (rst)
        ce |=> sosc_rdy_q == $past(sosc_stable && ctrl_q.secondary_osc_enable))
        else $error("secondary ready flag wrong");

    chk_field_pos: assert property (@(posedge clock) disable iff (rst)
        ce && rd_en && addr == `OSC_CTRL_ADDR |=> rdata_q[29:27] == $past(ctrl_q.pll_output_divide)
            && rdata_q[20:19] == $past(ctrl_q.periph_clock_divide))
        else $error("field position wrong in read data");

    chk_status_view: assert property (@(posedge clock) disable iff (rst)
        ce && rd_en && addr == `OSC_CTRL_ADDR
            |=> rdata_q[22:21] == $past({sosc_rdy_q, pb_rdy_q}))
        else $error("status bits wrong in read data");

    chk_write_taken: assert property (@(posedge clock) disable iff (rst)
        ce && ctrl_ok |=> ctrl_q.fast_rc_divide == $past(wdata[`POS_FRC_DIV+2:`POS_FRC_DIV]))
        else $error("unlocked write not taken");

    chk_switch_start: assert property (@(posedge clock) disable iff (rst)
        ce && sw_q == SW_IDLE && ctrl_q.switch_request |=> sw_q == SW_SWITCH)
        else $error("switch request not started");

    chk_write_relock: assert property (@(posedge clock) disable iff (rst)
        ce && ctrl_wr |=> lock_q == LOCKED)
        else $error("control write did not relock");
endmodule
`default_nettype wire

// ### sim/oscillator_control_register_bench.sv
// Self-checking bench for the oscillator control register
`timescale 1ns/100ps
`default_nettype none
`include "osc_params.svh"
module oscillator_control_register_bench
    import osc_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata_q;
    osc_cfg_t cfg = '{3'h5, 2'h3, 3'h2, 3'h1, 1'b1};
    logic sosc_stable = 1'b0;
    logic pll_lock = 1'b1;
    logic usb_pll_lock = 1'b0;
    logic pll_tick = 1'b1;
    logic frc_tick = 1'b0;
    osc_ctrl_t ctrl_q;
    logic sosc_rdy_q;
    logic pb_rdy_q;
    logic [2:0] div_tick_q;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [31:0] d;
    logic [31:0] p;
    logic [31:0] f;
    logic [31:0] b;

    oscillator_control_register #(.ADDR_W(4)) dut (.clock(clock), .rst(rst), .ce(ce),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
        .cfg(cfg), .sosc_stable(sosc_stable), .pll_lock(pll_lock),
        .usb_pll_lock(usb_pll_lock), .pll_tick(pll_tick), .frc_tick(frc_tick),
        .ctrl_q(ctrl_q), .sosc_rdy_q(sosc_rdy_q), .pb_rdy_q(pb_rdy_q),
        .div_tick_q(div_tick_q));

    // Clock and half-rate fast RC tick
    always #12.5 clock = ~clock;
    always @(posedge clock) begin
        frc_tick <= ~frc_tick;
    end

    // Hang guard
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register view as software reads it
    function automatic logic [31:0] v(input logic [2:0] pod, fast_rc_oscillator, input logic [1:0] pbd,
        input logic [2:0] mul, cur, nsrc, input logic [7:0] low, input logic sr, pr);
        return {2'h0, pod, fast_rc_oscillator, 1'h0, sr, pr, pbd, mul, 1'h0, cur, 1'h0, nsrc, low};
    endfunction

    // Write word with junk in unimplemented and read-only bits
    function automatic logic [31:0] w(input logic [2:0] pod, fast_rc_oscillator, input logic [1:0] pbd,
        input logic [2:0] mul, nsrc, input logic [7:0] low);
        return v(pod, fast_rc_oscillator, pbd, mul, 3'h0, nsrc, low, 1'b0, 1'b0) | 32'hC0E07000;
    endfunction

    task automatic check(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] x);
        addr <= a;
        wdata <= x;
        rd_en <= 1'b0;
        wr_en <= 1'b1;
        @(posedge clock);
    endtask

    task automatic idle(input int n);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        repeat (n) @(posedge clock);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] x);
        addr <= a;
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 x = rdata_q;
        @(posedge clock);
    endtask

    task automatic unlock();
        wr(`OSC_UNLOCK_ADDR, `OSC_KEY1);
        wr(`OSC_UNLOCK_ADDR, `OSC_KEY2);
    endtask

    // Count divided pulses over 512 cycles
    task automatic count();
        p = 0;
        f = 0;
        b = 0;
        repeat (512) begin
            @(posedge clock);
            #1 p = p + div_tick_q[0];
            f = f + div_tick_q[1];
            b = b + div_tick_q[2];
        end
        @(posedge clock);
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rd(`OSC_CTRL_ADDR, d);
        check("reset view", d, v(3'h5, `FRC_DIV_RST, 2'h3, 3'h2, 3'h1, 3'h1, 8'h02, 1'b0, 1'b1));
        count();
        check("pb rate at reset", b, 64);
        check("frc rate at reset", f, 128);
        check("pll rate at reset", p, 16);
        // Locked write is dropped
        wr(`OSC_CTRL_ADDR, w(3'h0, 3'h0, 2'h0, 3'h0, 3'h0, 8'h00));
        rd(`OSC_CTRL_ADDR, d);
        check("locked write", d, v(3'h5, 3'h1, 2'h3, 3'h2, 3'h1, 3'h1, 8'h22, 1'b0, 1'b1));
        // Divisor change, then a second write inside the settle window
        unlock();
        wr(`OSC_CTRL_ADDR, w(3'h0, 3'h0, 2'h0, 3'h2, 3'h1, 8'hFE));
        unlock();
        wr(`OSC_CTRL_ADDR, w(3'h0, 3'h3, 2'h2, 3'h2, 3'h1, 8'hFE));
        check("divisor busy port", pb_rdy_q, 1'b0);
        rd(`OSC_CTRL_ADDR, d);
        check("settling view", d, v(3'h0, 3'h3, 2'h0, 3'h2, 3'h1, 3'h1, 8'hBE, 1'b0, 1'b0));
        rd(`OSC_CTRL_ADDR, d);
        check("divisor ready", d[21], 1'b1);
        check("divisor ready port", pb_rdy_q, 1'b1);
        // Secondary oscillator ready follows stability
        sosc_stable <= 1'b1;
        idle(3);
        rd(`OSC_CTRL_ADDR, d);
        check("sosc ready on", d[22], 1'b1);
        check("sosc ready port", sosc_rdy_q, 1'b1);
        sosc_stable <= 1'b0;
        idle(3);
        rd(`OSC_CTRL_ADDR, d);
        check("sosc ready off", d[22], 1'b0);
        // A wrong key in the sequence relocks
        wr(`OSC_UNLOCK_ADDR, `OSC_KEY1);
        wr(`OSC_UNLOCK_ADDR, 32'h00000000);
        wr(`OSC_UNLOCK_ADDR, `OSC_KEY2);
        wr(`OSC_CTRL_ADDR, w(3'h0, 3'h7, 2'h0, 3'h2, 3'h1, 8'hFE));
        rd(`OSC_CTRL_ADDR, d);
        check("wrong key", d[26:24], 3'h3);
        rd(4'h8, d);
        check("unmapped read", d, 32'h0);
        // Clock source switch
        unlock();
        wr(`OSC_CTRL_ADDR, w(3'h0, 3'h3, 2'h0, 3'h2, 3'h3, 8'h03));
        idle(4);
        rd(`OSC_CTRL_ADDR, d);
        check("switch view", d, v(3'h0, 3'h3, 2'h0, 3'h2, 3'h3, 3'h3, 8'h22, 1'b0, 1'b1));
        check("switch port", {ctrl_q.switch_request, ctrl_q.current_source}, 4'h3);
        // Every divider code
        for (int c = 0; c < 8; c++) begin
            unlock();
            wr(`OSC_CTRL_ADDR, w(3'(c), 3'(c), 2'(c), 3'h2, 3'h3, 8'h02));
            idle(300);
            count();
            check("pll divide", p, 512 >> ((c == 7) ? 8 : c));
            check("frc divide", f, 256 >> ((c == 7) ? 8 : c));
            check("pb divide", b, 512 >> (c % 4));
        end
        give_verdict();
    end
endmodule
`default_nettype wire
